// File: core/floppy_control_command_unit.v
// control command unit of a floppy controller: specify, seek,
// recalibrate, read id, sense interrupt and sense drive status.
// assumes drive inputs synchronous to clk_i and a one-cycle-strobe
// register port with read data in the cycle after the read strobe.
//
// Notes on behaviour
// - control commands move no data; few interrupt
// - read id keeps first id field read
// - no mark by second index: abnormal, missing-mark
// - recalibrate clears cylinder, steps outward while low
// - track zero high ends recalibrate with seek-end
// - still low after 79 steps: seek-end, check
// - busy in command phase and while read id runs; overlap allowed
// - seek direction from present versus new cylinder
// - steps spaced by rate; equality ends seek
// - head address bit always reads zero
// - leaving power down zeroes cylinder and status
// - interrupt on read id result, positioning end
// - sense interrupt clears one cause, reports it
// - cause coding: polling, normal, abnormal end
// - sense drive status answers at once
// - specify sets head unload time after access
// - step rate sets spacing between step pulses
// - head load time before access; rate scaled
// - only dma mode; non-dma select forced zero
`timescale 1ns/1ps
`default_nettype none
`include "floppy_cmd_map.vh"

module floppy_control_command_unit #(
    parameter        DRIVES   = 4,
    parameter [23:0] TICK_CYC = `TICK_NS / `CLK_PERIOD_NS
) (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    input  wire        index_pulse_in_n_i,
    input  wire [3:0]  track_zero_in_n_i,
    input  wire [3:0]  write_protect_i,
    input  wire        id_valid_i,
    input  wire [7:0]  id_cyl_i,
    input  wire [7:0]  id_head_i,
    input  wire [7:0]  id_sector_i,
    input  wire [7:0]  id_size_i,
    output wire [3:0]  step_o,
    output wire [3:0]  dir_o,
    output reg         head_load_o,
    output wire        int_o,
    output wire        busy_o
);
    localparam R_IDLE   = 2'b00;
    localparam R_LOAD   = 2'b01;
    localparam R_SEARCH = 2'b10;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // status register 0 byte; head bit always zero
    function [7:0] st0_byte;
        input [1:0] ic;
        input       se;
        input       ec;
        input [1:0] drv;
        begin
            st0_byte = {ic, se, ec, 1'b0, 1'b0, drv};
        end
    endfunction

    // lowest drive with a pending completion
    function [1:0] first_set;
        input [3:0] v;
        begin
            if (v[0])
                first_set = 2'd0;
            else if (v[1])
                first_set = 2'd1;
            else if (v[2])
                first_set = 2'd2;
            else
                first_set = 2'd3;
        end
    endfunction

    // a zero field selects the longest delay
    function [8:0] delay_ticks;
        input [6:0] val;
        input [8:0] zero_ticks;
        input [2:0] shift;
        begin
            if (val == 7'h00)
                delay_ticks = zero_ticks;
            else
                delay_ticks = {2'b00, val} << shift;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    reg  [15:0] spec_r;
    reg  [2:0]  ctrl_r;
    reg         pd_prev_r;
    reg  [`TICK_W-1:0] div_r;
    reg         tick_r;
    reg  [3:0]  int_pend_r;
    reg         poll_pend_r;
    reg         rid_int_r;
    reg  [7:0]  rid_st0_r;
    reg  [7:0]  res0_r;
    reg  [7:0]  res1_r;
    reg  [7:0]  st1_r;
    reg  [31:0] idf_r;
    reg  [1:0]  rid_state_r;
    reg  [1:0]  rid_drv_r;
    reg  [1:0]  idx_cnt_r;
    reg         idx_prev_r;
    reg  [8:0]  load_r;
    reg  [8:0]  unload_r;

    wire [3:0]  seq_busy;
    wire [3:0]  seq_done;
    wire [3:0]  seq_ec;
    wire [31:0] pcn_all;

    wire        pd_exit = pd_prev_r & ~ctrl_r[`CT_PD];
    wire        cmd_wr  = wr_i && (addr_i == `A_CMD) && !ctrl_r[`CT_PD];
    wire [2:0]  op      = wdata_i[`CMD_OP];
    wire [1:0]  drv     = wdata_i[`CMD_DRV];
    wire        rid_go  = cmd_wr && (op == `OP_READ_ID) && (rid_state_r == R_IDLE);
    wire        sin_go  = cmd_wr && (op == `OP_SENSE_IN);
    wire        sdr_go  = cmd_wr && (op == `OP_SENSE_DR);
    wire        idx_fall = idx_prev_r & ~index_pulse_in_n_i;
    wire [1:0]  sel_drv = first_set(int_pend_r);
    wire [4:0]  step_gap = `STEP_UNIT_MAX - {1'b0, spec_r[`SP_SRT]};
    wire [`TICK_W-1:0] tick_lim = (TICK_CYC << ctrl_r[`CT_RATE]) - 24'h00_0001;

    // busy only while a command word is taken or read id runs
    assign busy_o = cmd_wr | (rid_state_r != R_IDLE);
    // interrupt line from pending causes
    assign int_o  = poll_pend_r | rid_int_r | (|int_pend_r);

    ////////////////////////////////////////////////////////////////////
    // rate tick divider; delays scale with data rate
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r  <= {`TICK_W{1'b0}};
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r >= tick_lim);
            if (div_r >= tick_lim)
                div_r <= {`TICK_W{1'b0}};
            else
                div_r <= div_r + 24'h00_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // one sequencer per drive, overlapped positioning
    genvar g;
    generate
        for (g = 0; g < DRIVES; g = g + 1) begin : drv_g
            step_seq u_seq (
                .clk_i              (clk_i),
                .reset_n_i          (reset_n_i),
                .tick_i             (tick_r),
                .clear_i            (pd_exit),
                .seek_i             (cmd_wr && (op == `OP_SEEK) && (drv == g)),
                .recal_i            (cmd_wr && (op == `OP_RECAL) && (drv == g)),
                .new_cylinder_i     (wdata_i[`CMD_NCYL]),
                .interval_i         (step_gap),
                .track_zero_in_n_i  (track_zero_in_n_i[g]),
                .step_o             (step_o[g]),
                .dir_o              (dir_o[g]),
                .present_cylinder_o (pcn_all[8*g+7:8*g]),
                .busy_o             (seq_busy[g]),
                .done_o             (seq_done[g]),
                .ec_o               (seq_ec[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // specify and control registers
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            spec_r    <= `SPEC_RST;
            ctrl_r    <= `CTRL_RST;
            pd_prev_r <= 1'b0;
        end else begin
            pd_prev_r <= ctrl_r[`CT_PD];
            if (cmd_wr && (op == `OP_SPECIFY)) begin
                spec_r          <= wdata_i[`CMD_SPEC];
                spec_r[`SP_ND]  <= 1'b0;
            end
            if (wr_i && (addr_i == `A_CTRL))
                ctrl_r <= wdata_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read id sequence with head load and unload timing
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rid_state_r <= R_IDLE;
            rid_drv_r   <= 2'd0;
            idx_cnt_r   <= 2'd0;
            idx_prev_r  <= 1'b1;
            load_r      <= 9'h000;
            unload_r    <= 9'h000;
            head_load_o <= 1'b0;
        end else begin
            idx_prev_r <= index_pulse_in_n_i;
            // head unload delay after the access ends
            if (head_load_o && (rid_state_r == R_IDLE) && tick_r) begin
                if (unload_r <= 9'h001)
                    head_load_o <= 1'b0;
                else
                    unload_r <= unload_r - 9'h001;
            end
            case (rid_state_r)
                R_IDLE: begin
                    if (rid_go) begin
                        rid_drv_r   <= drv;
                        idx_cnt_r   <= 2'd0;
                        head_load_o <= 1'b1;
                        load_r      <= delay_ticks(spec_r[`SP_HLT],
                                           `HLT_ZERO_TICKS, `HLT_UNIT_SHIFT);
                        rid_state_r <= head_load_o ? R_SEARCH : R_LOAD;
                    end
                end
                R_LOAD: begin
                    // head settles before the search starts
                    if (tick_r) begin
                        if (load_r <= 9'h001)
                            rid_state_r <= R_SEARCH;
                        else
                            load_r <= load_r - 9'h001;
                    end
                end
                R_SEARCH: begin
                    if (idx_fall)
                        idx_cnt_r <= idx_cnt_r + 2'd1;
                    if (id_valid_i || (idx_fall && (idx_cnt_r == 2'd1))) begin
                        rid_state_r <= R_IDLE;
                        unload_r    <= delay_ticks({3'b000, spec_r[`SP_HUT]},
                                           `HUT_ZERO_TICKS, `HUT_UNIT_SHIFT);
                    end
                end
                default: rid_state_r <= R_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt causes and result bytes
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_pend_r  <= 4'h0;
            poll_pend_r <= 1'b1;
            rid_int_r   <= 1'b0;
            rid_st0_r   <= 8'h00;
            res0_r      <= 8'h00;
            res1_r      <= 8'h00;
            st1_r       <= 8'h00;
            idf_r       <= 32'h0000_0000;
        end else if (pd_exit) begin
            // status information cleared on wake
            int_pend_r  <= 4'h0;
            poll_pend_r <= 1'b0;
            rid_int_r   <= 1'b0;
            rid_st0_r   <= 8'h00;
            res0_r      <= 8'h00;
            res1_r      <= 8'h00;
            st1_r       <= 8'h00;
        end else begin
            // sense interrupt: report one cause, clear it
            if (sin_go) begin
                if (poll_pend_r) begin
                    poll_pend_r <= 1'b0;
                    res0_r <= st0_byte(`IC_POLL, 1'b0, 1'b0, 2'd0);
                    res1_r <= 8'h00;
                end else if (rid_int_r) begin
                    rid_int_r <= 1'b0;
                    res0_r    <= rid_st0_r;
                    res1_r    <= pcn_all[8*rid_drv_r +: 8];
                end else if (|int_pend_r) begin
                    int_pend_r[sel_drv] <= 1'b0;
                    res0_r <= st0_byte(seq_ec[sel_drv] ? `IC_ABNORMAL : `IC_NORMAL,
                                       1'b1, seq_ec[sel_drv], sel_drv);
                    res1_r <= pcn_all[8*sel_drv +: 8];
                end else begin
                    res0_r <= st0_byte(`IC_INVALID, 1'b0, 1'b0, 2'd0);
                    res1_r <= 8'h00;
                end
            end
            // drive status straight to result byte 1
            if (sdr_go)
                res1_r <= {1'b0, write_protect_i[drv], 1'b1,
                           track_zero_in_n_i[drv], 2'b00, drv};
            // positioning end raises the line; set beats clear
            int_pend_r <= (int_pend_r & ~((sin_go && !poll_pend_r && !rid_int_r)
                          ? (4'h1 << sel_drv) : 4'h0)) | seq_done;
            if (rid_state_r == R_SEARCH) begin
                if (id_valid_i) begin
                    // first id field found is kept
                    idf_r     <= {id_size_i, id_sector_i, id_head_i, id_cyl_i};
                    st1_r     <= 8'h00;
                    rid_st0_r <= st0_byte(`IC_NORMAL, 1'b0, 1'b0, rid_drv_r);
                    res0_r    <= st0_byte(`IC_NORMAL, 1'b0, 1'b0, rid_drv_r);
                    rid_int_r <= 1'b1;
                end else if (idx_fall && (idx_cnt_r == 2'd1)) begin
                    st1_r     <= `ST1_MA;
                    rid_st0_r <= st0_byte(`IC_ABNORMAL, 1'b0, 1'b0, rid_drv_r);
                    res0_r    <= st0_byte(`IC_ABNORMAL, 1'b0, 1'b0, rid_drv_r);
                    rid_int_r <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read port, data only in the cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `A_CMD:  rdata_o <= {24'h00_0000, seq_busy | int_pend_r,
                                     2'b00, int_o, busy_o};
                `A_SPEC: rdata_o <= {16'h0000, spec_r};
                `A_CTRL: rdata_o <= {29'h0000_0000, ctrl_r};
                `A_RES0: rdata_o <= {24'h00_0000, res0_r};
                `A_RES1: rdata_o <= {24'h00_0000, res1_r};
                `A_ST1:  rdata_o <= {24'h00_0000, st1_r};
                `A_IDF:  rdata_o <= idf_r;
                `A_PCN:  rdata_o <= pcn_all;
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// File: core/floppy_cmd_map.vh
// constants of the floppy control command unit: register map,
// command word layout, status fields and timing.
// assumes a 100 MHz clock and inclusion by bare name.
`ifndef FLOPPY_CMD_MAP_VH
`define FLOPPY_CMD_MAP_VH

// clock and timing base
`define CLK_PERIOD_NS   10
`define TICK_NS         250000
`define TICK_W          24
`define RECAL_STEPS     7'h4f
`define STEP_UNIT_MAX   5'h10
`define HUT_ZERO_TICKS  9'h100
`define HUT_UNIT_SHIFT  4
`define HLT_ZERO_TICKS  9'h100
`define HLT_UNIT_SHIFT  1

// register byte addresses
`define A_CMD    8'h00
`define A_SPEC   8'h04
`define A_CTRL   8'h08
`define A_RES0   8'h0c
`define A_RES1   8'h10
`define A_ST1    8'h14
`define A_IDF    8'h18
`define A_PCN    8'h1c

// command word fields
`define CMD_OP    2:0
`define CMD_DRV   5:4
`define CMD_NCYL  15:8
`define CMD_SPEC  31:16

// command codes
`define OP_SPECIFY  3'h1
`define OP_SENSE_DR 3'h2
`define OP_RECAL    3'h3
`define OP_SENSE_IN 3'h4
`define OP_SEEK     3'h5
`define OP_READ_ID  3'h6

// timing register fields
`define SP_SRT   3:0
`define SP_HUT   7:4
`define SP_HLT   14:8
`define SP_ND    15
`define SPEC_RST 16'h0000

// control register fields
`define CT_PD    0
`define CT_RATE  2:1
`define CTRL_RST 3'h0

// interrupt code values
`define IC_NORMAL   2'b00
`define IC_ABNORMAL 2'b01
`define IC_INVALID  2'b10
`define IC_POLL     2'b11

// status register 1 missing mark bit
`define ST1_MA 8'h01

`endif

// File: core/step_seq.v
// one drive's head positioning sequencer: seek and recalibrate.
// assumes tick_i is a one-cycle enable and track zero is synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "floppy_cmd_map.vh"

module step_seq (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire       tick_i,
    input  wire       clear_i,
    input  wire       seek_i,
    input  wire       recal_i,
    input  wire [7:0] new_cylinder_i,
    input  wire [4:0] interval_i,
    input  wire       track_zero_in_n_i,
    output reg        step_o,
    output reg        dir_o,
    output reg  [7:0] present_cylinder_o,
    output wire       busy_o,
    output reg        done_o,
    output reg        ec_o
);
    localparam S_IDLE  = 2'b00;
    localparam S_CHECK = 2'b01;
    localparam S_STEP  = 2'b10;
    localparam S_WAIT  = 2'b11;

    reg [1:0] state_r;
    reg       recal_r;
    reg [7:0] target_r;
    reg [6:0] count_r;
    reg [4:0] wait_r;

    assign busy_o = (state_r != S_IDLE);

    ////////////////////////////////////////////////////////////////////
    // stepping state machine
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r            <= S_IDLE;
            recal_r            <= 1'b0;
            target_r           <= 8'h00;
            count_r            <= 7'h00;
            wait_r             <= 5'h00;
            step_o             <= 1'b0;
            dir_o              <= 1'b0;
            present_cylinder_o <= 8'h00;
            done_o             <= 1'b0;
            ec_o               <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (clear_i) begin
                // leaving power down wipes position and status
                state_r            <= S_IDLE;
                step_o             <= 1'b0;
                present_cylinder_o <= 8'h00;
                ec_o               <= 1'b0;
            end else begin
                case (state_r)
                    S_IDLE: begin
                        if (recal_i) begin
                            present_cylinder_o <= 8'h00;
                            count_r            <= 7'h00;
                            recal_r            <= 1'b1;
                            ec_o               <= 1'b0;
                            state_r            <= S_CHECK;
                        end else if (seek_i) begin
                            target_r <= new_cylinder_i;
                            recal_r  <= 1'b0;
                            ec_o     <= 1'b0;
                            state_r  <= S_CHECK;
                        end
                    end
                    S_CHECK: begin
                        if (recal_r) begin
                            dir_o <= 1'b0;
                            if (track_zero_in_n_i) begin
                                done_o  <= 1'b1;
                                state_r <= S_IDLE;
                            end else if (count_r == `RECAL_STEPS) begin
                                ec_o    <= 1'b1;
                                done_o  <= 1'b1;
                                state_r <= S_IDLE;
                            end else begin
                                step_o  <= 1'b1;
                                state_r <= S_STEP;
                            end
                        end else if (present_cylinder_o == target_r) begin
                            done_o  <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            // step in when below target, else out
                            dir_o   <= (present_cylinder_o < target_r);
                            step_o  <= 1'b1;
                            state_r <= S_STEP;
                        end
                    end
                    S_STEP: begin
                        // pulse stands one tick, then the spacing runs
                        if (tick_i) begin
                            step_o  <= 1'b0;
                            wait_r  <= interval_i;
                            state_r <= S_WAIT;
                            if (recal_r)
                                count_r <= count_r + 7'h01;
                            else if (dir_o)
                                present_cylinder_o <= present_cylinder_o + 8'h01;
                            else
                                present_cylinder_o <= present_cylinder_o - 8'h01;
                        end
                    end
                    S_WAIT: begin
                        // compare again after every pulse
                        if (tick_i) begin
                            if (wait_r <= 5'h01)
                                state_r <= S_CHECK;
                            else
                                wait_r <= wait_r - 5'h01;
                        end
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/fcu_monitor.sv
// checker for the floppy control command unit ports.
// assumes one clock, async active-low reset, bound from the bench top.
`timescale 1ns/1ps
`default_nettype none
`include "floppy_cmd_map.vh"
module fcu_monitor #(
    parameter logic [23:0] TICK_CYC = 24'd4
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [3:0]  step_o,
    input wire logic [3:0]  dir_o,
    input wire logic        head_load_o,
    input wire logic        int_o,
    input wire logic        busy_o
);
    logic [23:0] hi_r;
    wire         cmd_w = wr_i && addr_i == `A_CMD;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // length of the current step pulse on drive 0
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) hi_r <= '0;
        else hi_r <= step_o[0] ? hi_r + 24'd1 : '0;
    end
    ////////////////////////////////////////////////////////////////
    property p_cmd_busy; cmd_w |-> busy_o; endproperty
    a_cmd_busy: assert property (p_cmd_busy) else $error("busy low at command");
    property p_pos_free;
        cmd_w && wdata_i[2:0] == `OP_SEEK && !$past(busy_o) |=> !busy_o;
    endproperty
    a_pos_free: assert property (p_pos_free) else $error("busy during seek");
    property p_sd_free;
        cmd_w && wdata_i[2:0] == `OP_SENSE_DR && !$past(busy_o) |=> !busy_o;
    endproperty
    a_sd_free: assert property (p_sd_free) else $error("drive status busy");
    property p_step_w; $fell(step_o[0]) |-> hi_r != 24'd0 && hi_r <= TICK_CYC; endproperty
    a_step_w: assert property (p_step_w) else $error("step width wrong");
    property p_gap; $fell(step_o[0]) |-> !step_o[0] [*3]; endproperty
    a_gap: assert property (p_gap) else $error("step gap short");
    property p_dir; step_o[0] && $past(step_o[0]) |-> $stable(dir_o[0]); endproperty
    a_dir: assert property (p_dir) else $error("direction moved in step");
    property p_head; rd_i && addr_i == `A_RES0 |=> !rdata_o[2]; endproperty
    a_head: assert property (p_head) else $error("head bit set");
    property p_nd; rd_i && addr_i == `A_SPEC |=> !rdata_o[15]; endproperty
    a_nd: assert property (p_nd) else $error("non dma bit set");
    c_step: cover property ($rose(step_o[0]));
    c_int: cover property ($fell(int_o));
    c_head: cover property ($rose(head_load_o));
endmodule
`default_nettype wire

// File: tb/drive_model.sv
// model of four floppy drives: head position, track zero, index, ids.
// assumes step pulses high and direction 1 meaning inward.
`timescale 1ns/1ps
`default_nettype none
module drive_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] step_i,
    input  wire logic [3:0] dir_i,
    input  wire logic       head_load_i,
    input  wire logic       no_mark_i,
    output logic            index_n_o,
    output logic [3:0]      tz_n_o,
    output logic            id_valid_o,
    output logic [7:0]      id_cyl_o
);
    int         pos[4] = '{3, 0, 5, 100};
    int         cnt = 0;
    logic [3:0] st_q = '0;
    // heads move one track per step edge, never below zero
    always @(posedge clk_i) begin
        st_q <= step_i;
        cnt <= (cnt == 99) ? 0 : cnt + 1;
        for (int i = 0; i < 4; i++)
            if (step_i[i] && !st_q[i])
                pos[i] <= dir_i[i] ? pos[i] + 1 : (pos[i] > 0 ? pos[i] - 1 : 0);
    end
    // track zero high at cylinder zero; one id field each turn
    always_comb begin
        for (int i = 0; i < 4; i++) tz_n_o[i] = (pos[i] == 0);
        index_n_o = !(cnt < 2);
        id_valid_o = head_load_i && !no_mark_i && cnt == 50;
        id_cyl_o = id_valid_o ? 8'(pos[0]) : 8'(cnt); // junk outside the field
    end
endmodule
`default_nettype wire

// File: tb/floppy_control_command_unit_tb_top.sv
// self-checking bench for the floppy control command unit.
// assumes the drive model as far side and a short tick divider.
`timescale 1ns/1ps
`default_nettype none
`include "floppy_cmd_map.vh"
module floppy_control_command_unit_tb_top;
    logic        clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, no_mark = 0;
    logic [7:0]  addr_i = '0, idc, tg[4];
    logic [31:0] wdata_i = '0, rdata_o, q;
    logic [3:0]  wp_i = '0, tz_n, step_o, dir_o;
    logic        idx_n, idv, head_load_o, int_o, busy_o;
    int          err_total = 0, n_tests = 0, cyc = 0, seen, i;
    floppy_control_command_unit #(.TICK_CYC(24'd4)) floppy_control_command_unit_inst (
        .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .index_pulse_in_n_i(idx_n), .track_zero_in_n_i(tz_n), .write_protect_i(wp_i),
        .id_valid_i(idv), .id_cyl_i(idc), .id_head_i(8'h01), .id_sector_i(8'h07),
        .id_size_i(8'h02), .step_o, .dir_o, .head_load_o, .int_o, .busy_o);
    drive_model drive_model_inst (.clk_i, .step_i(step_o), .dir_i(dir_o),
        .head_load_i(head_load_o), .no_mark_i(no_mark), .index_n_o(idx_n),
        .tz_n_o(tz_n), .id_valid_o(idv), .id_cyl_o(idc));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] cmd(input logic [2:0] op, input logic [1:0] d,
                                        input logic [7:0] c);
        return {16'h0000, c, 2'b00, d, 1'b0, op};
    endfunction
    function automatic logic [31:0] st0e(input logic [1:0] d);
        return (d == 2'd3) ? 32'h0000_0073 : (32'h0000_0020 | d);
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i); wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i); addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i); rd_i <= 1'b0;
        @(negedge clk_i); q = rdata_o;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wint;
        for (int k = 0; k < 3000 && int_o !== 1'b1; k++) @(negedge clk_i);
        chk({31'b0, int_o}, 32'h1);
    endtask
    task automatic sense; wr(`A_CMD, cmd(`OP_SENSE_IN, 2'd0, 8'h00)); rd(`A_RES0); endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial forever #5 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin err_total++; results(); end
    end
    initial begin
        q = $urandom(33);
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
        sense(); chk(q, 32'h0000_00c0);
        wr(`A_CMD, 32'h811f_0001); rd(`A_SPEC); chk(q, 32'h0000_011f);
        chk({31'b0, int_o}, 32'h0);
        $display("test specify done");
        for (i = 0; i < 4; i++) wr(`A_CMD, cmd(`OP_RECAL, i[1:0], 8'h00));
        seen = 0;
        for (i = 0; i < 4; i++) begin
            wint(); sense(); seen |= 1 << q[1:0];
            chk(q, st0e(q[1:0]));
        end
        chk(seen, 32'hf); chk(drive_model_inst.pos[3], 32'd21);
        $display("test recalibrate done");
        tg[0] = 8'h00; tg[1] = 8'($urandom % 40); tg[2] = 8'($urandom % 40); tg[3] = 8'h27;
        for (i = 0; i < 4; i++) begin
            wr(`A_CMD, cmd(`OP_SEEK, 2'd0, tg[i])); wint(); sense();
            chk(q, 32'h0000_0020); rd(`A_RES1); chk(q, {24'h0, tg[i]});
            chk(drive_model_inst.pos[0], {24'h0, tg[i]});
        end
        $display("test seek done");
        @(posedge clk_i) wp_i <= 4'($urandom);
        wr(`A_CMD, cmd(`OP_SENSE_DR, 2'd2, 8'h00)); rd(`A_RES1);
        chk(q, {24'h0, 1'b0, wp_i[2], 1'b1, 1'b1, 2'b00, 2'd2});
        chk({31'b0, int_o}, 32'h0);
        $display("test drive status done");
        wr(`A_CMD, cmd(`OP_READ_ID, 2'd0, 8'h00)); wint();
        rd(`A_IDF); chk(q, 32'h0207_0127);
        sense(); chk(q, 32'h0); chk({31'b0, int_o}, 32'h0);
        no_mark <= 1'b1;
        wr(`A_CMD, cmd(`OP_READ_ID, 2'd0, 8'h00)); wint();
        rd(`A_ST1); chk(q, 32'h1); sense(); chk(q, 32'h0000_0040);
        $display("test read id done");
        wr(`A_CTRL, 32'h1); wr(`A_CTRL, 32'h0);
        rd(`A_PCN); chk(q, 32'h0); sense(); chk(q, 32'h0000_0080);
        $display("test power down done");
        results();
    end
endmodule
bind floppy_control_command_unit fcu_monitor #(.TICK_CYC(TICK_CYC)) mon_inst (
    .clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .step_o,
    .dir_o, .head_load_o, .int_o, .busy_o);
`default_nettype wire
